// ===== src/lane_unit_defines.svh
// offsets, field positions, reset values and timing counts for the lane unit
`ifndef LANE_UNIT_DEFINES_SVH
`define LANE_UNIT_DEFINES_SVH

// register offsets, byte addresses on the wishbone slave
`define LU_CTRL_OFFSET 8'h00
`define LU_STATUS_OFFSET 8'h04
`define LU_MAP_OFFSET 8'h08
`define LU_ERRCNT_OFFSET 8'h0c

// control register fields
`define LU_CTRL_SWAP_BIT 0
`define LU_CTRL_RESET 1'b0

// status register fields
`define LU_STAT_MEM_ENDIAN_BIT 0
`define LU_STAT_EFF_ENDIAN_BIT 1
`define LU_STAT_CAPTURED_BIT 2
`define LU_STAT_BUSY_BIT 3

// map register fields
`define LU_MAP_PAGE_LSB 0
`define LU_MAP_PAGE_MSB 3
`define LU_MAP_RESET 4'h0

// strap capture
`define LU_ENDIAN_RESET 1'b0
`define LU_STRAP_SETTLE_CYCLES 2'h3

// general register zero
`define LU_ZERO_REG 5'h00

`endif

// ===== src/lane_unit_pkg.sv
// types shared by the lane unit modules
package lane_unit_pkg;

    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_HALF = 2'h1,
        SIZE_TRIPLE = 2'h2,
        SIZE_WORD = 2'h3
    } access_size_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MEM,
        ST_INTERLOCK
    } lsu_state_t;

endpackage

// ===== src/addr_map.sv
// virtual to physical address mapping
`timescale 1ns/1ns
module addr_map
    import lane_unit_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // mapping inputs
    input wire logic [ADDR_W-1:0] virtual_addr_i,
    input wire logic [3:0] page_i,
    // mapped address
    output logic [ADDR_W-1:0] physical_addr_o
);

    logic [3:0] top_sum;

    // kernel half is direct mapped, user half relocated by page
    always_comb begin
        top_sum = 4'(virtual_addr_i[ADDR_W-1:ADDR_W-4] + page_i);
        if (virtual_addr_i[ADDR_W-1]) begin
            physical_addr_o = {3'h0, virtual_addr_i[ADDR_W-4:0]};
        end else begin
            physical_addr_o = {top_sum, virtual_addr_i[ADDR_W-5:0]};
        end
    end

endmodule

// ===== src/lane_steer.sv
// byte lane selection and data steering for one access
`timescale 1ns/1ns
module lane_steer
    import lane_unit_pkg::*;
(
    // access description
    input wire logic [1:0] size_i,
    input wire logic [1:0] addr_lo_i,
    input wire logic big_endian_i,
    input wire logic load_signed_i,
    // data
    input wire logic [31:0] store_data_i,
    input wire logic [31:0] mem_rdata_i,
    // results
    output logic [3:0] byte_en_o,
    output logic [31:0] mem_wdata_o,
    output logic [31:0] load_data_o,
    output logic addr_err_o
);

    // bit k set for byte number k; bit 4 flags an illegal pair
    function automatic logic [4:0] byte_pick(input logic [1:0] size, input logic [1:0] lo);
        logic [4:0] r;
        r = 5'h10;
        unique case (access_size_t'(size))
            SIZE_WORD: if (lo == 2'h0) r = 5'h0f;
            SIZE_TRIPLE: begin
                if (lo == 2'h0) r = 5'h07;
                if (lo == 2'h1) r = 5'h0e;
            end
            SIZE_HALF: begin
                if (lo == 2'h0) r = 5'h03;
                if (lo == 2'h2) r = 5'h0c;
            end
            SIZE_BYTE: r = {1'b0, 4'(4'h1 << lo)};
        endcase
        return r;
    endfunction

    logic [4:0] pick;
    logic [1:0] shift_bytes;
    logic [31:0] keep_mask;
    logic [31:0] raw;
    logic sign_bit;

    assign pick = byte_pick(size_i, addr_lo_i);
    assign addr_err_o = pick[4];

    // lane j carries byte j little endian, byte 3-j big endian
    genvar j;
    generate
        for (j = 0; j < 4; j++) begin : g_lane
            assign byte_en_o[j] = !pick[4] && (big_endian_i ? pick[3-j] : pick[j]);
        end
    endgenerate

    always_comb begin
        shift_bytes = big_endian_i ? 2'(2'h3 - addr_lo_i - size_i) : addr_lo_i;
        keep_mask = 32'hffff_ffff >> {2'(2'h3 - size_i), 3'h0};
        raw = (mem_rdata_i >> {shift_bytes, 3'h0}) & keep_mask;
        sign_bit = raw[{size_i, 3'h7}];
        load_data_o = raw;
        if (load_signed_i && sign_bit) begin
            load_data_o = raw | ~keep_mask;
        end
        mem_wdata_o = (store_data_i & keep_mask) << {shift_bytes, 3'h0};
    end

endmodule

// ===== src/load_store_endian_lane_unit.sv
// load/store endian and byte lane unit with wishbone control registers
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
`include "lane_unit_defines.svh"
module load_store_endian_lane_unit
    import lane_unit_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int ERRCNT_W = 16
) (
    // clock, reset, enable
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // endian strap pin
    input wire logic endian_strap_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pipeline request
    input wire logic req_valid_i,
    input wire logic req_load_i,
    input wire logic req_signed_i,
    input wire logic [1:0] req_size_i,
    input wire logic [ADDR_W-1:0] virtual_addr_i,
    input wire logic [31:0] store_data_i,
    input wire logic [4:0] dest_reg_i,
    input wire logic user_mode_i,
    input wire logic [4:0] next_src_a_i,
    input wire logic [4:0] next_src_b_i,
    output logic req_done_o,
    output logic stall_o,
    output logic addr_error_o,
    // writeback
    output logic wb_valid_o,
    output logic [4:0] wb_reg_o,
    output logic [31:0] wb_data_o,
    // immediate forming
    input wire logic [15:0] imm_i,
    output logic [31:0] imm_sext_o,
    output logic [31:0] imm_upper_o,
    // endian state
    output logic memory_endian_o,
    output logic effective_endian_o,
    // memory side
    input wire logic cache_enable_i,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [ADDR_W-1:0] physical_addr_o,
    output logic [3:0] byte_en_o,
    output logic [31:0] mem_wdata_o,
    output logic cache_fill_o,
    output logic [31:0] cache_fill_data_o
);

    // strap synchroniser and capture
    logic [2:0] strap_sync_reg;
    logic [1:0] settle_reg, settle_next;
    logic captured_reg, captured_next;
    logic memory_endian_setting_reg, memory_endian_setting_next;

    always_comb begin
        settle_next = settle_reg;
        captured_next = captured_reg;
        memory_endian_setting_next = memory_endian_setting_reg;
        if (settle_reg != `LU_STRAP_SETTLE_CYCLES) begin
            settle_next = 2'(settle_reg + 2'h1);
        end else if (!captured_reg && strap_sync_reg[1] == strap_sync_reg[2]) begin
            captured_next = 1'b1;
            memory_endian_setting_next = strap_sync_reg[2];
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            strap_sync_reg <= 3'h0;
            settle_reg <= 2'h0;
            captured_reg <= 1'b0;
            memory_endian_setting_reg <= `LU_ENDIAN_RESET;
        end else if (ce_i) begin
            strap_sync_reg <= {strap_sync_reg[1:0], endian_strap_i};
            settle_reg <= settle_next;
            captured_reg <= captured_next;
            memory_endian_setting_reg <= memory_endian_setting_next;
        end
    end

    // wishbone register file
    logic user_swap_enable_bit_reg, user_swap_enable_bit_next;
    logic [3:0] map_page_reg, map_page_next;
    logic [ERRCNT_W-1:0] errcnt_reg, errcnt_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic bus_write;
    lsu_state_t state_reg, state_next;

    assign bus_write = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;

    always_comb begin
        user_swap_enable_bit_next = user_swap_enable_bit_reg;
        map_page_next = map_page_reg;
        errcnt_next = errcnt_reg;
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        rdata_next = 32'h0;
        if (bus_write && wb_adr_i == `LU_CTRL_OFFSET && wb_sel_i[0]) begin
            user_swap_enable_bit_next = wb_dat_i[`LU_CTRL_SWAP_BIT];
        end
        if (bus_write && wb_adr_i == `LU_MAP_OFFSET && wb_sel_i[0]) begin
            map_page_next = wb_dat_i[`LU_MAP_PAGE_MSB:`LU_MAP_PAGE_LSB];
        end
        // a write of any value clears the counter; a new error wins
        if (bus_write && wb_adr_i == `LU_ERRCNT_OFFSET) begin
            errcnt_next = '0;
        end
        if (addr_error_o && ce_i) begin
            errcnt_next = (errcnt_reg == '1) ? errcnt_reg : ERRCNT_W'(errcnt_reg + 1'b1);
        end
        unique case (wb_adr_i)
            `LU_CTRL_OFFSET: rdata_next[`LU_CTRL_SWAP_BIT] = user_swap_enable_bit_reg;
            `LU_STATUS_OFFSET: begin
                rdata_next[`LU_STAT_MEM_ENDIAN_BIT] = memory_endian_setting_reg;
                rdata_next[`LU_STAT_EFF_ENDIAN_BIT] = effective_endian_o;
                rdata_next[`LU_STAT_CAPTURED_BIT] = captured_reg;
                rdata_next[`LU_STAT_BUSY_BIT] = state_reg != ST_IDLE;
            end
            `LU_MAP_OFFSET: rdata_next[`LU_MAP_PAGE_MSB:`LU_MAP_PAGE_LSB] = map_page_reg;
            `LU_ERRCNT_OFFSET: rdata_next[ERRCNT_W-1:0] = errcnt_reg;
            default: rdata_next = 32'h0;
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            user_swap_enable_bit_reg <= `LU_CTRL_RESET;
            map_page_reg <= `LU_MAP_RESET;
            errcnt_reg <= '0;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end else if (ce_i) begin
            user_swap_enable_bit_reg <= user_swap_enable_bit_next;
            map_page_reg <= map_page_next;
            errcnt_reg <= errcnt_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // endian selection
    logic user_endian_swap;
    assign user_endian_swap = user_swap_enable_bit_reg && user_mode_i;
    assign effective_endian_o = memory_endian_setting_reg ^ user_endian_swap;
    assign memory_endian_o = memory_endian_setting_reg;

    // request side steering and mapping
    logic [ADDR_W-1:0] mapped_addr;
    logic [3:0] req_byte_en;
    logic [31:0] req_wdata;
    logic req_err;

    addr_map #(.ADDR_W(ADDR_W)) u_map (
        .virtual_addr_i(virtual_addr_i),
        .page_i(map_page_reg),
        .physical_addr_o(mapped_addr)
    );

    lane_steer u_req_lanes (
        .size_i(req_size_i),
        .addr_lo_i(virtual_addr_i[1:0]),
        .big_endian_i(effective_endian_o),
        .load_signed_i(req_signed_i),
        .store_data_i(store_data_i),
        .mem_rdata_i(32'h0),
        .byte_en_o(req_byte_en),
        .mem_wdata_o(req_wdata),
        .load_data_o(),
        .addr_err_o(req_err)
    );

    // access sequencer state
    logic load_reg, load_next;
    logic signed_reg, signed_next;
    logic big_reg, big_next;
    logic [1:0] size_reg, size_next;
    logic [1:0] lo_reg, lo_next;
    logic [4:0] dest_reg, dest_next;
    logic mem_req_reg, mem_req_next;
    logic mem_we_reg, mem_we_next;
    logic [ADDR_W-1:0] paddr_reg, paddr_next;
    logic [3:0] ben_reg, ben_next;
    logic [31:0] wdata_reg, wdata_next;
    logic done_reg, done_next;
    logic err_reg, err_next;
    logic wbv_reg, wbv_next;
    logic [4:0] wbr_reg, wbr_next;
    logic [31:0] wbd_reg, wbd_next;
    logic fill_reg, fill_next;
    logic [31:0] fill_data_reg, fill_data_next;
    logic [31:0] load_value;
    logic use_hit;

    lane_steer u_rsp_lanes (
        .size_i(size_reg),
        .addr_lo_i(lo_reg),
        .big_endian_i(big_reg),
        .load_signed_i(signed_reg),
        .store_data_i(32'h0),
        .mem_rdata_i(mem_rdata_i),
        .byte_en_o(),
        .mem_wdata_o(),
        .load_data_o(load_value),
        .addr_err_o()
    );

    assign use_hit = dest_reg != `LU_ZERO_REG && (next_src_a_i == dest_reg || next_src_b_i == dest_reg);

    always_comb begin
        state_next = state_reg;
        load_next = load_reg;
        signed_next = signed_reg;
        big_next = big_reg;
        size_next = size_reg;
        lo_next = lo_reg;
        dest_next = dest_reg;
        mem_req_next = mem_req_reg;
        mem_we_next = mem_we_reg;
        paddr_next = paddr_reg;
        ben_next = ben_reg;
        wdata_next = wdata_reg;
        done_next = 1'b0;
        err_next = 1'b0;
        wbv_next = 1'b0;
        wbr_next = wbr_reg;
        wbd_next = wbd_reg;
        fill_next = 1'b0;
        fill_data_next = fill_data_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (req_valid_i && captured_reg) begin
                    if (req_err) begin
                        err_next = 1'b1;
                        done_next = 1'b1;
                    end else begin
                        state_next = ST_MEM;
                        load_next = req_load_i;
                        signed_next = req_signed_i;
                        big_next = effective_endian_o;
                        size_next = req_size_i;
                        lo_next = virtual_addr_i[1:0];
                        dest_next = dest_reg_i;
                        mem_req_next = 1'b1;
                        mem_we_next = !req_load_i;
                        paddr_next = {mapped_addr[ADDR_W-1:2], 2'h0};
                        ben_next = req_byte_en;
                        wdata_next = req_wdata;
                    end
                end
            end
            ST_MEM: begin
                if (mem_ack_i) begin
                    mem_req_next = 1'b0;
                    mem_we_next = 1'b0;
                    done_next = 1'b1;
                    if (load_reg) begin
                        wbv_next = dest_reg != `LU_ZERO_REG;
                        wbr_next = dest_reg;
                        wbd_next = load_value;
                        fill_next = cache_enable_i;
                        fill_data_next = mem_rdata_i;
                    end
                    if (load_reg && use_hit) begin
                        state_next = ST_INTERLOCK;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_INTERLOCK: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= ST_IDLE;
            load_reg <= 1'b0;
            signed_reg <= 1'b0;
            big_reg <= 1'b0;
            size_reg <= 2'h0;
            lo_reg <= 2'h0;
            dest_reg <= 5'h0;
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
            paddr_reg <= '0;
            ben_reg <= 4'h0;
            wdata_reg <= 32'h0;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            wbv_reg <= 1'b0;
            wbr_reg <= 5'h0;
            wbd_reg <= 32'h0;
            fill_reg <= 1'b0;
            fill_data_reg <= 32'h0;
        end else if (ce_i) begin
            state_reg <= state_next;
            load_reg <= load_next;
            signed_reg <= signed_next;
            big_reg <= big_next;
            size_reg <= size_next;
            lo_reg <= lo_next;
            dest_reg <= dest_next;
            mem_req_reg <= mem_req_next;
            mem_we_reg <= mem_we_next;
            paddr_reg <= paddr_next;
            ben_reg <= ben_next;
            wdata_reg <= wdata_next;
            done_reg <= done_next;
            err_reg <= err_next;
            wbv_reg <= wbv_next;
            wbr_reg <= wbr_next;
            wbd_reg <= wbd_next;
            fill_reg <= fill_next;
            fill_data_reg <= fill_data_next;
        end
    end

    assign mem_req_o = mem_req_reg;
    assign mem_we_o = mem_we_reg;
    assign physical_addr_o = paddr_reg;
    assign byte_en_o = ben_reg;
    assign mem_wdata_o = wdata_reg;
    assign req_done_o = done_reg;
    assign addr_error_o = err_reg;
    assign wb_valid_o = wbv_reg;
    assign wb_reg_o = wbr_reg;
    assign wb_data_o = wbd_reg;
    assign cache_fill_o = fill_reg;
    assign cache_fill_data_o = fill_data_reg;
    assign stall_o = state_reg == ST_INTERLOCK;

    // immediate forming
    logic [31:0] sext_reg, sext_next;
    logic [31:0] upper_reg, upper_next;

    always_comb begin
        sext_next = {{16{imm_i[15]}}, imm_i};
        upper_next = {imm_i, 16'h0};
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sext_reg <= 32'h0;
            upper_reg <= 32'h0;
        end else if (ce_i) begin
            sext_reg <= sext_next;
            upper_reg <= upper_next;
        end
    end

    assign imm_sext_o = sext_reg;
    assign imm_upper_o = upper_reg;

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_load_hit;
        ce_i && state_reg == ST_MEM && mem_ack_i && load_reg && use_hit;
    endsequence

    sequence s_one_stall;
        stall_o ##1 !stall_o;
    endsequence

    a_kernel_endian: assert property (!user_mode_i |-> effective_endian_o == memory_endian_o)
        else $error("kernel mode endian differs from memory endian");
    a_swap_reverses: assert property (user_mode_i && user_swap_enable_bit_reg |-> effective_endian_o != memory_endian_o)
        else $error("user swap did not reverse endian");
    a_interlock_once: assert property (s_load_hit |=> s_one_stall)
        else $error("load use interlock not exactly one cycle");
    a_error_no_lanes: assert property (ce_i && state_reg == ST_IDLE && req_valid_i && captured_reg && req_err |=> addr_error_o && !mem_req_o)
        else $error("address error issued a memory access");
    a_store_lanes: assert property (mem_req_o && mem_we_o |-> byte_en_o != 4'h0)
        else $error("store without byte enables");
    a_byte_onehot: assert property (ce_i && state_reg == ST_IDLE && req_valid_i && captured_reg && req_size_i == SIZE_BYTE |=> $onehot(byte_en_o))
        else $error("byte access not on a single lane");
    a_zero_discard: assert property (wb_valid_o |-> wb_reg_o != `LU_ZERO_REG)
        else $error("write to register zero");
    a_mapped_addr: assert property (ce_i && state_reg == ST_IDLE && req_valid_i && captured_reg && !req_err |=> physical_addr_o[ADDR_W-1:2] == $past(mapped_addr[ADDR_W-1:2]))
        else $error("physical address not from mapping");
    a_imm_sext: assert property (nrst_i && ce_i |=> imm_sext_o[31:16] == {16{$past(imm_i[15])}})
        else $error("sign extension wrong");
    a_imm_upper: assert property (nrst_i && ce_i |=> imm_upper_o == {$past(imm_i), 16'h0})
        else $error("upper immediate wrong");
    a_fill_cached: assert property (cache_fill_o |-> req_done_o && cache_fill_data_o == $past(mem_rdata_i) && $past(cache_enable_i) && $past(load_reg))
        else $error("cache fill without cached load");

endmodule

// ===== bench/mem_partner.sv
// memory model behind the lane unit, random answer delay
`timescale 1ns/1ns
module mem_partner (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // request side
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [31:0] addr_i,
    input wire logic [3:0] ben_i,
    input wire logic [31:0] wdata_i,
    // answer side
    output logic ack_o,
    output logic [31:0] rdata_o
);
    logic [31:0] mem [16];
    int wait_n;
    initial for (int i = 0; i < 16; i++) mem[i] = 32'h0;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_o <= 1'b0;
            rdata_o <= 32'h0;
            wait_n <= 0;
        end else if (ack_o) begin
            ack_o <= 1'b0;
            rdata_o <= ~rdata_o;
            wait_n <= $urandom % 3;
        end else if (req_i && wait_n > 0) begin
            wait_n <= wait_n - 1;
            rdata_o <= ~rdata_o;
        end else if (req_i) begin
            ack_o <= 1'b1;
            rdata_o <= mem[addr_i[5:2]];
            for (int j = 0; j < 4; j++) if (we_i && ben_i[j]) mem[addr_i[5:2]][8*j+:8] <= wdata_i[8*j+:8];
        end else
            rdata_o <= ~rdata_o;
    end
endmodule

// ===== bench/load_store_endian_lane_unit_test.sv
// self-checking bench for the load/store lane unit
`timescale 1ns/1ns
module load_store_endian_lane_unit_test;
    import lane_unit_pkg::*;
    typedef struct {logic err; logic wbv; logic [4:0] rg; logic [31:0] d; logic fill; logic [31:0] fd; logic stl;} note_t;
    note_t q[$];
    note_t n2;
    logic mclk_i = '0, nrst_i = '0, ce_i = '1, endian_strap_i = '0, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0;
    logic req_valid_i = '0, req_load_i = '0, req_signed_i = '0, user_mode_i = '0, cache_enable_i = '0;
    logic [7:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = '0, store_data_i = '0, virtual_addr_i = '0;
    logic [1:0] req_size_i = '0;
    logic [4:0] dest_reg_i = '0, next_src_a_i = '0, next_src_b_i = 5'h1f;
    logic [15:0] imm_i = '0, imm_d = '0;
    logic [31:0] wb_dat_o, wb_data_o, imm_sext_o, imm_upper_o, mem_rdata_i, physical_addr_o, mem_wdata_o, cache_fill_data_o;
    logic wb_ack_o, req_done_o, stall_o, addr_error_o, wb_valid_o, memory_endian_o, effective_endian_o;
    logic mem_ack_i, mem_req_o, mem_we_o, cache_fill_o, live = '0, chk_stl = '0, exp_stl = '0;
    logic [4:0] wb_reg_o;
    logic [3:0] byte_en_o;
    logic [31:0] sh [16];
    int err_count = 0, checks = 0, cyc_n = 0, swap = 0, pg = 0;

    load_store_endian_lane_unit dut (.mclk_i, .nrst_i, .ce_i, .endian_strap_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .req_valid_i, .req_load_i, .req_signed_i,
        .req_size_i, .virtual_addr_i, .store_data_i, .dest_reg_i, .user_mode_i, .next_src_a_i, .next_src_b_i,
        .req_done_o, .stall_o, .addr_error_o, .wb_valid_o, .wb_reg_o, .wb_data_o, .imm_i, .imm_sext_o,
        .imm_upper_o, .memory_endian_o, .effective_endian_o, .cache_enable_i, .mem_ack_i, .mem_rdata_i,
        .mem_req_o, .mem_we_o, .physical_addr_o, .byte_en_o, .mem_wdata_o, .cache_fill_o, .cache_fill_data_o);
    mem_partner mem (.clk_i(mclk_i), .nrst_i, .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(physical_addr_o),
        .ben_i(byte_en_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

    always #50 mclk_i = ~mclk_i;

    task chk(input logic ok, input string m);
        checks++;
        if (!ok) begin
            err_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task results;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task wbt(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task acc(input logic ld, input int s, input int lo, input int u);
        logic [31:0] w, m, dt;
        note_t n;
        int be, ill, k, idx, c, src;
        be = endian_strap_i ^ (swap & u);
        ill = (lo + s > 3) || (s == 1 && lo == 1);
        k = be ? 3 - lo - s : lo;
        m = ill ? 32'h0 : (32'hffff_ffff >> 8 * (3 - s)) << 8 * k;
        idx = $urandom % 16;
        c = $urandom % 2;
        src = $urandom % 4;
        dt = $urandom;
        w = sh[idx];
        n.err = ill;
        n.rg = $urandom % 4;
        n.wbv = ld && !ill && n.rg != 0;
        n.d = (w & m) >> 8 * k;
        if (dt[0] && n.d[8*s+7]) n.d = n.d | ~(32'hffff_ffff >> 8 * (3 - s));
        n.fill = ld && !ill && c;
        n.fd = w;
        n.stl = n.wbv && n.rg == src;
        q.push_back(n);
        @(posedge mclk_i);
        req_valid_i <= 1'b1;
        req_load_i <= ld;
        req_signed_i <= dt[0];
        req_size_i <= s[1:0];
        virtual_addr_i <= {!u[0], 31'(idx << 2 | lo)};
        store_data_i <= dt;
        dest_reg_i <= n.rg;
        next_src_a_i <= src[4:0];
        user_mode_i <= u[0];
        cache_enable_i <= c[0];
        @(posedge mclk_i);
        chk(effective_endian_o === be[0], "effective endian");
        if (ill) req_valid_i <= 1'b0;
        else begin
            do @(posedge mclk_i); while (mem_req_o !== 1'b1);
            chk(byte_en_o === {m[24], m[16], m[8], m[0]}, "byte lanes");
            chk(physical_addr_o === (u ? pg << 28 | idx << 2 : idx << 2) && mem_we_o === !ld, "mapped address");
            if (!ld) chk((mem_wdata_o & m) === ((dt << 8 * k) & m), "store lanes");
            if (!ld) sh[idx] = (w & ~m) | ((dt << 8 * k) & m);
            while (mem_ack_i !== 1'b1) @(posedge mclk_i);
            req_valid_i <= 1'b0;
        end
        @(posedge mclk_i);
    endtask

    task rst(input logic e);
        logic [31:0] r;
        @(posedge mclk_i);
        nrst_i <= 1'b0;
        endian_strap_i <= e;
        repeat (8) @(posedge mclk_i);
        nrst_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        chk(memory_endian_o === e, "strap capture");
        wbt(1'b0, 8'h04, 32'h0, r);
        chk(r[2:0] === {1'b1, e, e}, "status after reset");
    endtask

    always @(posedge mclk_i) begin
        imm_i <= $urandom;
        cyc_n++;
        if (cyc_n == 20000) begin
            chk(1'b0, "timeout");
            results;
        end
    end

    always @(posedge mclk_i) begin
        if (live && nrst_i) chk(imm_sext_o === {{16{imm_d[15]}}, imm_d}, "sign extend");
        if (live && nrst_i) chk(imm_upper_o === {imm_d, 16'h0}, "upper immediate");
        if (chk_stl) chk(stall_o === exp_stl, "interlock length");
        chk_stl = 1'b0;
        if (req_done_o === 1'b1 && q.size() == 0) chk(1'b0, "extra done");
        else if (req_done_o === 1'b1) begin
            n2 = q.pop_front();
            chk(addr_error_o === n2.err, "address error");
            chk(wb_valid_o === n2.wbv, "writeback valid");
            if (n2.wbv) chk(wb_data_o === n2.d && wb_reg_o === n2.rg, "load data");
            chk(cache_fill_o === n2.fill, "cache fill");
            if (n2.fill) chk(cache_fill_data_o === n2.fd, "fill word");
            chk(stall_o === n2.stl, "interlock");
            exp_stl = 1'b0;
            chk_stl = 1'b1;
        end
        imm_d = imm_i;
        live = nrst_i;
    end

    initial begin
        logic [31:0] r;
        void'($urandom(32232));
        for (int i = 0; i < 16; i++) sh[i] = 32'h0;
        for (int e = 0; e < 2; e++) begin
            rst(e[0]);
            pg = e + 3;
            wbt(1'b1, 8'h08, pg, r);
            for (int sw = 0; sw < 2; sw++) begin
                wbt(1'b1, 8'h00, sw, r);
                swap = sw;
                for (int u = 0; u < 2; u++) for (int s = 0; s < 4; s++) for (int lo = 0; lo < 4; lo++) begin
                    acc(1'b0, s, lo, u);
                    acc(1'b1, s, lo, u);
                end
            end
            wbt(1'b0, 8'h0c, 32'h0, r);
            chk(r[15:0] === 16'h0038, "error count");
            wbt(1'b1, 8'h0c, 32'h0, r);
            wbt(1'b0, 8'h0c, 32'h0, r);
            chk(r === 32'h0, "error count clear");
            wbt(1'b0, 8'h10, 32'h0, r);
            chk(r === 32'h0, "unmapped read");
            wbt(1'b1, 8'h08, 32'h5, r);
            wbt(1'b0, 8'h08, 32'h0, r);
            chk(r[3:0] === 4'h5, "map readback");
        end
        results;
    end
endmodule
